// File: design/rtc_pkg.sv
// Purpose: shared constants for the reloadable timer counter
// Assumes: 32-bit AHB-Lite register access, 20 MHz hclk
// Notes: offsets are byte addresses of aligned words
package rtc_pkg;
  localparam logic [11:0] rtc_off_ctrl = 12'h000;
  localparam logic [11:0] rtc_off_count = 12'h004;
  localparam logic [11:0] rtc_off_reload = 12'h008;
  localparam logic [11:0] rtc_off_status = 12'h00c;
  // control field positions
  localparam int rtc_ctl_enable = 0;
  localparam int rtc_ctl_mode_lo = 1;
  localparam int rtc_ctl_mode_hi = 2;
  localparam int rtc_ctl_pre_lo = 3;
  localparam int rtc_ctl_pre_hi = 5;
  localparam int rtc_ctl_polarity = 6;
  localparam int rtc_ctl_out_en = 7;
  // reset values
  localparam logic [7:0] rtc_ctrl_reset = 8'h00;
  localparam logic [15:0] rtc_count_reset = 16'h0001;
  localparam logic [15:0] rtc_reload_reset = 16'h0000;
  localparam logic [15:0] rtc_restart_value = 16'h0001;
  localparam logic [2:0] rtc_max_pre_shift = 3'h7;
  // mode encodings
  localparam logic [1:0] rtc_mode_one_shot = 2'h0;
  localparam logic [1:0] rtc_mode_continuous = 2'h1;
  localparam logic [1:0] rtc_mode_counter = 2'h2;
endpackage

// File: design/rtc_prescaler.sv
// Purpose: divide-by-2^n enable pulse generator for the timer
// Assumes: single clock, enable held while counting
// Notes: restarts its count whenever the timer is disabled
`timescale 1ns/1ps
`default_nettype none
module rtc_prescaler
  import rtc_pkg::*;
#(
  parameter int width = 7
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic [2:0] shift,
  // output
  output logic tick
);
  logic [width-1:0] div_count;
  logic [width-1:0] limit;

  assign limit = width'((8'h01 << shift) - 8'h01);
  assign tick = run && (div_count == limit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_count <= '0;
    end else if (!run || tick) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + width'(1);
    end
  end

  a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && shift == 3'h1 && $stable(shift) |=> !tick)
    else $error("prescaler ticked on consecutive cycles at divide two");
endmodule
`default_nettype wire

// File: design/rtc_timer.sv
// Purpose: 16-bit reloadable timer with one-shot, continuous and counter modes
// Assumes: AHB-Lite slave, zero wait states, OKAY answers only
// Notes: interrupt is a one-cycle event pulse toward the system controller
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module rtc_timer
  import rtc_pkg::*;
#(
  parameter int count_width = 16
) (
  // ahb-lite
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer pins
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_irq
);
  logic [7:0] ctrl;
  logic [count_width-1:0] count;
  logic [count_width-1:0] reload;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic in_meta;
  logic in_sync;
  logic in_prev;
  logic out_level;
  logic pulse_active;
  logic seen_reload;
  logic tick;
  logic edge_seen;
  logic step;
  logic match;
  logic enable;
  logic [1:0] mode;
  logic [31:0] next_rdata;

  assign enable = ctrl[rtc_ctl_enable];
  assign mode = ctrl[rtc_ctl_mode_hi:rtc_ctl_mode_lo];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: writes land in the data phase, reads answer at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr == rtc_off_ctrl) begin
      next_rdata = {24'h00_0000, ctrl};
    end else if (haddr == rtc_off_count) begin
      next_rdata = {16'h0000, count};
    end else if (haddr == rtc_off_reload) begin
      next_rdata = {16'h0000, reload};
    end else if (haddr == rtc_off_status) begin
      next_rdata = {30'h0000_0000, seen_reload, out_level};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchroniser
  // two flops, then compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      in_meta <= timer_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  assign edge_seen = ctrl[rtc_ctl_polarity] ? (in_sync && !in_prev) : (!in_sync && in_prev);

  rtc_prescaler u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(enable && mode != rtc_mode_counter),
    .shift(ctrl[rtc_ctl_pre_hi:rtc_ctl_pre_lo]),
    .tick(tick)
  );

  // timed modes use prescaler; counter bypasses it
  assign step = enable && ((mode == rtc_mode_counter) ? edge_seen : tick);
  assign match = (count == reload);

  ////////////////////////////////////////////////////////////////////////
  // control register; one-shot clears its own enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= rtc_ctrl_reset;
    end else if (wr_pend && wr_addr == rtc_off_ctrl) begin
      ctrl <= hwdata[7:0];
    end else if (step && match && mode == rtc_mode_one_shot) begin
      ctrl[rtc_ctl_enable] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload <= rtc_reload_reset;
    end else if (wr_pend && wr_addr == rtc_off_reload) begin
      reload <= hwdata[count_width-1:0];
    end
  end

  // counter: written value is only the first start point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= rtc_count_reset;
    end else if (wr_pend && wr_addr == rtc_off_count) begin
      count <= hwdata[count_width-1:0];
    end else if (step && match) begin
      count <= rtc_restart_value;
    end else if (step) begin
      count <= count + count_width'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output level and event pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_level <= 1'b0;
      pulse_active <= 1'b0;
      timer_irq <= 1'b0;
      seen_reload <= 1'b0;
    end else begin
      timer_irq <= step && match;
      pulse_active <= step && match && mode == rtc_mode_one_shot && ctrl[rtc_ctl_out_en];
      if (wr_pend && wr_addr == rtc_off_status) begin
        seen_reload <= 1'b0;
      end
      if (step && match) begin
        seen_reload <= 1'b1;
      end
      if (!enable) begin
        out_level <= ctrl[rtc_ctl_polarity];
      end else if (step && match && mode != rtc_mode_one_shot && ctrl[rtc_ctl_out_en]) begin
        out_level <= !out_level;
      end
    end
  end

  // one-shot inverts for one cycle only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_out <= 1'b0;
    end else if (step && match && mode == rtc_mode_one_shot && ctrl[rtc_ctl_out_en]) begin
      timer_out <= !ctrl[rtc_ctl_polarity];
    end else if (mode == rtc_mode_one_shot) begin
      timer_out <= ctrl[rtc_ctl_polarity];
    end else begin
      timer_out <= ctrl[rtc_ctl_out_en] && enable ? out_level : ctrl[rtc_ctl_polarity];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_oneshot_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    step && match && mode == rtc_mode_one_shot && !wr_pend |=> !enable && count == rtc_restart_value)
    else $error("one-shot did not stop and reload one");
  a_cont_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    step && match && mode == rtc_mode_continuous && !wr_pend |=> enable && count == rtc_restart_value)
    else $error("continuous mode stopped at reload");
  a_irq_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    step && match |=> timer_irq ##1 !timer_irq || $past(step && match))
    else $error("interrupt pulse missing");
  a_wrap_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    step && !match && count == 16'hffff && !wr_pend |=> count == 16'h0000)
    else $error("counter did not wrap to zero");
  a_pulse_one: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_active && !(step && match) && mode == rtc_mode_one_shot |=> timer_out == ctrl[rtc_ctl_polarity])
    else $error("one-shot pulse lasted more than one cycle");
  a_toggle_out: assert property (@(posedge hclk) disable iff (!hresetn)
    step && match && mode == rtc_mode_counter && ctrl[rtc_ctl_out_en] && !wr_pend |=> out_level != $past(out_level))
    else $error("output did not toggle at reload");
  a_counter_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    enable && mode == rtc_mode_counter && !edge_seen && !wr_pend |=> $stable(count))
    else $error("counter mode advanced without an edge");
  a_idle_level: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable && !wr_pend |=> out_level == $past(ctrl[rtc_ctl_polarity]))
    else $error("idle output level not from polarity");
  a_timed_no_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    enable && mode != rtc_mode_counter && !tick && !wr_pend |=> $stable(count))
    else $error("timed mode advanced without a prescaler tick");

  c_oneshot: cover property (@(posedge hclk) step && match && mode == rtc_mode_one_shot);
  c_cont: cover property (@(posedge hclk) step && match && mode == rtc_mode_continuous);
  c_counter: cover property (@(posedge hclk) step && match && mode == rtc_mode_counter);
endmodule
`default_nettype wire

// File: verif/rtc_pin_src.sv
// Purpose: external count source on the timer input pin
// Assumes: started by a one-cycle start strobe
// Notes: three-clock phases keep clear of the input rate limit
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_src (
  // clock
  input wire logic hclk,
  // control
  input wire logic [7:0] pulses,
  input wire logic start,
  // pin
  output logic timer_in,
  output logic busy
);
  initial begin
    timer_in = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge hclk);
      if (start) begin
        busy <= 1'b1;
        repeat (pulses) begin
          repeat (3) @(posedge hclk);
          timer_in <= 1'b1;
          repeat (3) @(posedge hclk);
          timer_in <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: self-checking bench for the reloadable timer
// Assumes: ahb-lite master, 50 ns hclk
// Notes: longest reload is skipped, it needs millions of cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtc_pkg::*;
  typedef struct {logic [2:0] sh; logic [15:0] rl; int per;} rtc_row_type;
  logic hclk, hresetn, hsel, hwrite, timer_in, start, busy, ot;
  logic hreadyout, hresp, timer_out, timer_irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pulses;
  logic [31:0] hwdata, hrdata, rd;
  int err_total, total_checks, n, k, p, ni, nh;
  int t[2];
  rtc_row_type rows[4] = '{'{3'h0, 16'h1, 1}, '{3'h0, 16'h3, 3}, '{3'h2, 16'h3, 12}, '{3'h7, 16'h2, 256}};
  rtc_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_in(timer_in), .timer_out(timer_out), .timer_irq(timer_irq));
  rtc_pin_src src_u (.hclk(hclk), .pulses(pulses), .start(start), .timer_in(timer_in), .busy(busy));
  ////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task hang(input string nm);
    err_total++;
    $display("mismatch %s exp done seen timeout", nm);
    summarize;
  endtask
  // one single-word transfer; the wait on hready is bounded
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    for (k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) hang("hready");
      if (k == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
      end
    end
    rd = hrdata;
  endtask
  task wirq(input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (timer_irq !== 1'b1 && n < lim);
    if (timer_irq !== 1'b1) hang("irq");
  endtask
  function logic [7:0] cw(input logic oe, input logic pol, input logic [2:0] sh, input logic [1:0] md);
    return {oe, pol, sh, md, 1'b1};
  endfunction
  // source paced by the pin model
  task pin(input logic [7:0] np);
    pulses <= np;
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
    @(posedge hclk);
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    if (busy !== 1'b0) hang("source");
    repeat (4) @(posedge hclk);
  endtask
  task cfg(input logic [7:0] c, input logic [15:0] cnt, input logic [15:0] rl);
    bus(1'b1, rtc_off_ctrl, 32'h0);
    bus(1'b1, rtc_off_ctrl, {24'h0, c & 8'hfe});
    bus(1'b1, rtc_off_count, {16'h0, cnt});
    bus(1'b1, rtc_off_reload, {16'h0, rl});
    bus(1'b1, rtc_off_ctrl, {24'h0, c});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, start, haddr, htrans, hsize, hwdata, pulses} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, rtc_off_ctrl, 32'h0);
    chk("ctrl_rst", rd, {24'h0, rtc_ctrl_reset});
    bus(1'b0, rtc_off_count, 32'h0);
    chk("count_rst", rd, {16'h0, rtc_count_reset});
    bus(1'b0, 12'h010, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      cfg(cw(1'b1, 1'b0, rows[i].sh, rtc_mode_continuous), 16'h1, rows[i].rl);
      wirq(400);
      ot = timer_out;
      p = 0;
      do begin
        @(posedge hclk);
        p++;
      end while (timer_irq !== 1'b1 && p < 400);
      chk("period", p, rows[i].per);
      chk("toggle", timer_out, {31'h0, ~ot});
      $display("test period row %0d done", i);
    end
    bus(1'b0, rtc_off_reload, 32'h0);
    chk("reload_rd", rd, 32'h2);
    cfg(cw(1'b0, 1'b0, 3'h0, rtc_mode_continuous), 16'hffff, 16'h2);
    // reload 2 is only met after a wrap
    wirq(12);
    $display("test wrap done");
    for (int j = 0; j < 2; j++) begin
      cfg(cw(1'b1, 1'b0, 3'h1, rtc_mode_one_shot), 16'h1, j ? 16'h9 : 16'h5);
      ni = 0;
      nh = 0;
      for (int c = 0; c < 60; c++) begin
        @(posedge hclk);
        if (timer_irq === 1'b1) t[j] = c;
        ni += (timer_irq === 1'b1);
        nh += (timer_out === 1'b1);
      end
      chk("os_irq", ni, 1);
      chk("os_pulse", nh, 1);
      bus(1'b0, rtc_off_ctrl, 32'h0);
      chk("os_enable", rd[0], 1'b0);
      bus(1'b0, rtc_off_count, 32'h0);
      chk("os_count", rd, 32'h1);
    end
    chk("os_span", t[1] - t[0], 8);
    $display("test one-shot done");
    bus(1'b1, rtc_off_ctrl, {24'h0, cw(1'b1, 1'b1, 3'h0, rtc_mode_counter) & 8'hfe});
    repeat (2) @(posedge hclk);
    chk("out_level", timer_out, 1'b1);
    // counter starts from one; top prescale must be ignored
    cfg(cw(1'b1, 1'b1, 3'h7, rtc_mode_counter), 16'h1, 16'h6);
    pin(8'h5);
    bus(1'b0, rtc_off_count, 32'h0);
    chk("edges", rd, 32'h6);
    // one more edge meets the reload and restarts from one
    pin(8'h1);
    bus(1'b0, rtc_off_count, 32'h0);
    chk("restart", rd, 32'h1);
    chk("cnt_toggle", timer_out, 32'h0);
    $display("test counter done");
    summarize;
  end
endmodule
`default_nettype wire
